//--- common/fsq_params.svh
// constants of the flash row write and id/config access sequencer
// assumes a 20 MHz system clock and byte addressed 32-bit register words
// Contract
// (R1) stall cpu for whole 2 ms flash write
// (R2) firmware selects flash, clears erase, sets gate
// (R3) firmware erases row, fills holding registers first
// (R4) pointer stays inside loaded holding range
// (R5) full row update takes about 6 ms
// (R6) firmware verifies row by table reads
// (R7) reset during write sets write error flag
// (R8) write start gated by write enable gate
// (R9) one key unlock covers exactly one write
// (R10) firmware keeps gate cleared between writes
// (R11) hardware never clears write enable gate
// (R12) space select 01/11 reaches id/config space
// (R13) ids and config writable, device ids read-only
// (R14) decode user id, config, device id ranges
// (R15) table read stalls cpu, loads table latch; code loads the latch in one bus access without raising CPU_STALL
// (R16) undefined id/config address reads zero
// (R17) firmware loads pointer and latch before write
// (R18) protected or invalid config write sets error; code accepts config writes with CONFIG_WRITE_PROTECT high, errors when low
// (R19) config byte write self-erases, no erase select
// (R20) config write stalls, clears start, sets done
// (R21) new config value visible when cpu resumes
// (R22) firmware writes 55h, aah, then start bit
// (R23) select 10 is flash; read start refused there
// (R24) protected or invalid flash write sets error
// (R25) flash write done: holding to ones, done set; code keeps holding registers after an erase
// (R26) write to device id range refused with error
`ifndef FSQ_PARAMS_SVH
`define FSQ_PARAMS_SVH

// register byte offsets
`define FSQ_OFS_CTRL 5'h00
`define FSQ_OFS_KEY 5'h04
`define FSQ_OFS_PTR 5'h08
`define FSQ_OFS_LATCH 5'h0c
`define FSQ_OFS_OP 5'h10
`define FSQ_OFS_STAT 5'h14

// memory_control_reg, table op and status register fields
`define FSQ_CTRL_RD 0
`define FSQ_CTRL_WR 1
`define FSQ_CTRL_WRITE_ENABLE_GATE 2
`define FSQ_CTRL_ERR 3
`define FSQ_CTRL_FREE 4
`define FSQ_CTRL_SEL 6
`define FSQ_OP_TABLE_READ_OP 0
`define FSQ_OP_TABLE_WRITE_OP 1
`define FSQ_OP_INC 2
`define FSQ_STAT_DONE 0
`define FSQ_STAT_BUSY 1

`define FSQ_SEL_PFM 2'b10
`define FSQ_KEY_FIRST 8'h55
`define FSQ_KEY_SECOND 8'haa

// id and configuration space
`define FSQ_UID_BASE 22'h200000
`define FSQ_UID_LAST 22'h20000f
`define FSQ_CFG_BASE 22'h300000
`define FSQ_CFG_LAST 22'h30000b
`define FSQ_DID_BASE 22'h3ffffc
`define FSQ_CFG_BYTES 12
`define FSQ_UID_BYTES 16

`define FSQ_HOLD_BYTES 64
`define FSQ_HOLD_AW 6
`define FSQ_ERASED_BYTE 8'hff
`define FSQ_CTRL_RST 8'h00

// timing
`define FSQ_CLK_HZ 20000000
`define FSQ_US_DIV (`FSQ_CLK_HZ / 1000000)
`define FSQ_PROG_MS 2
`define FSQ_PROG_US (`FSQ_PROG_MS * 1000)
`define FSQ_UPDATE_MS 6
`define FSQ_CFG_US 100

`endif

//--- common/fsq_pkg.sv
// types of the flash sequencer
// assumes fsq_params.svh on the include path
`include "fsq_params.svh"

package fsq_pkg;

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_ARMED} fsq_key_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PFM, SEQ_CFG} fsq_seq_t;

  typedef struct packed {
    logic [7:0] pre;
    logic [15:0] cnt;
    logic busy;
    logic done;
  } fsq_tmr_t;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    fsq_seq_t seq;
    logic [1:0] sel;
    logic rd;
    logic wr;
    logic write_enable_gate;
    logic err;
    logic free;
    logic done;
    logic stall;
    logic [21:0] ptr;
    logic [21:0] wptr;
    logic [7:0] lat;
    logic [`FSQ_HOLD_BYTES-1:0][7:0] hold;
    logic [`FSQ_UID_BYTES-1:0][7:0] uid;
    logic [`FSQ_CFG_BYTES-1:0][7:0] cfg;
  } fsq_state_t;

endpackage

//--- design/fsq_timer.sv
// programming timer: microsecond prescaler and duration counter
// assumes load is at least one
`timescale 1ns/100ps
`default_nettype none

module fsq_timer
  import fsq_pkg::*;
#(
  parameter int DIV = `FSQ_US_DIV
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic abort,
  input wire logic [15:0] load,
  output logic done,
  output logic busy
);

  fsq_tmr_t s;
  fsq_tmr_t n;
  logic tick;

  always_comb begin
    n = s;
    n.done = 1'b0;
    tick = (s.pre == 8'(DIV - 1));
    if (abort) begin
      n.busy = 1'b0;
    end else if (start) begin
      n.busy = 1'b1;
      n.cnt = load;
      n.pre = 8'h00;
    end else if (s.busy) begin
      n.pre = tick ? 8'h00 : s.pre + 8'h01;
      if (tick) begin
        n.cnt = s.cnt - 16'h0001;
        if (s.cnt == 16'h0001) begin
          n.busy = 1'b0;
          n.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign done = s.done;
  assign busy = s.busy;

endmodule

`default_nettype wire

//--- design/fsq_unlock.sv
// unlock key tracker: two key bytes arm exactly one start attempt
// assumes one-cycle strobes for each accepted register write
`timescale 1ns/100ps
`default_nettype none

module fsq_unlock
  import fsq_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic other_wr,
  input wire logic start_try,
  output logic armed
);

  fsq_key_t s;
  fsq_key_t n;

  always_comb begin
    n = s;
    unique case (s)
      KEY_IDLE: begin
        if (key_wr && key_data == `FSQ_KEY_FIRST) begin
          n = KEY_GOT1;
        end
      end
      KEY_GOT1: begin
        if (key_wr && key_data == `FSQ_KEY_SECOND) begin
          n = KEY_ARMED;
        end else if (key_wr && key_data == `FSQ_KEY_FIRST) begin
          n = KEY_GOT1;
        end else if (key_wr || other_wr || start_try) begin
          n = KEY_IDLE;
        end
      end
      KEY_ARMED: begin
        // any write spends the arming, used or not
        if (key_wr || other_wr || start_try) begin
          n = KEY_IDLE; // R9
        end
      end
      default: n = KEY_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= KEY_IDLE;
    end else begin
      s <= n;
    end
  end

  assign armed = (s == KEY_ARMED);

endmodule

`default_nettype wire

//--- design/fsq_top.sv
// flash row write and id/config access sequencer, avalon-mm slave
// assumes a cpu that stalls on waitrequest and on CPU_STALL
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module fsq_top
  import fsq_pkg::*;
#(
  parameter int PFM_AW = 12,
  parameter logic [15:0] PROG_US = 16'(`FSQ_PROG_US),
  parameter logic [15:0] CFG_US = 16'(`FSQ_CFG_US),
  // identifier values are arbitrary
  parameter logic [15:0] DEV_ID = 16'h1234,
  parameter logic [15:0] REV_ID = 16'h0001
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic EXT_RESET_EVT,
  input wire logic WDT_RESET_EVT,
  input wire logic CONFIG_WRITE_PROTECT,
  input wire logic PFM_WRITE_PROTECT,
  output logic CPU_STALL,
  output logic MEMORY_DONE_FLAG,
  output logic [8*`FSQ_CFG_BYTES-1:0] CONFIG_WORDS
);

  localparam int PFM_BYTES = 1 << PFM_AW;

  // ==========================================================
  // state
  fsq_state_t s;
  fsq_state_t n;
  logic [7:0] pfm [0:PFM_BYTES-1];

  logic req;
  logic key_wr;
  logic other_wr;
  logic start_try;
  logic armed;
  logic tmr_start;
  logic tmr_abort;
  logic [15:0] tmr_load;
  logic tmr_done;
  logic pfm_commit;
  logic cpu_reset;
  logic in_uid;
  logic in_cfg;
  logic in_did;
  logic in_pfm;
  logic [7:0] id_byte;
  logic [31:0] wmerge;

  // ==========================================================
  // address decode of the table pointer
  always_comb begin
    in_uid = s.ptr >= `FSQ_UID_BASE && s.ptr <= `FSQ_UID_LAST; // R14
    in_cfg = s.ptr >= `FSQ_CFG_BASE && s.ptr <= `FSQ_CFG_LAST; // R14
    in_did = s.ptr >= `FSQ_DID_BASE; // R14
    in_pfm = (s.ptr >> PFM_AW) == 22'h000000;
    id_byte = 8'h00; // R16
    if (s.sel[0]) begin // R12
      if (in_uid) begin
        id_byte = s.uid[s.ptr[3:0]];
      end else if (in_cfg) begin
        id_byte = s.cfg[s.ptr[3:0]];
      end else if (in_did) begin
        unique case (s.ptr[1:0])
          2'b00: id_byte = REV_ID[7:0];
          2'b01: id_byte = REV_ID[15:8];
          2'b10: id_byte = DEV_ID[7:0];
          2'b11: id_byte = DEV_ID[15:8];
        endcase
      end
    end else if (s.sel == `FSQ_SEL_PFM && in_pfm) begin // R23
      id_byte = pfm[s.ptr[PFM_AW-1:0]];
    end
  end

  // byte-lane merge of a write onto the old register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // sequencer and register file
  always_comb begin
    n = s;
    n.waitreq = 1'b1;
    n.rd = 1'b0;
    key_wr = 1'b0;
    other_wr = 1'b0;
    start_try = 1'b0;
    tmr_start = 1'b0;
    tmr_load = PROG_US; // R1 R5
    pfm_commit = 1'b0;
    cpu_reset = EXT_RESET_EVT || WDT_RESET_EVT;
    tmr_abort = cpu_reset;
    wmerge = 32'h00000000;
    // the bus waits out a write in progress, which stalls the cpu
    req = (AVS_READ || AVS_WRITE) && s.waitreq && !s.stall; // R1 R20
    if (req) begin
      n.waitreq = 1'b0;
      n.rdata = 32'h00000000;
    end
    if (req && AVS_READ) begin
      unique case (AVS_ADDRESS)
        `FSQ_OFS_CTRL: begin
          n.rdata[`FSQ_CTRL_SEL +: 2] = s.sel;
          n.rdata[`FSQ_CTRL_FREE] = s.free;
          n.rdata[`FSQ_CTRL_ERR] = s.err;
          n.rdata[`FSQ_CTRL_WRITE_ENABLE_GATE] = s.write_enable_gate;
          n.rdata[`FSQ_CTRL_WR] = s.wr;
          n.rdata[`FSQ_CTRL_RD] = s.rd;
        end
        `FSQ_OFS_PTR: n.rdata = {10'h000, s.ptr};
        `FSQ_OFS_LATCH: n.rdata = {24'h000000, s.lat};
        `FSQ_OFS_STAT: begin
          n.rdata[`FSQ_STAT_DONE] = s.done;
          n.rdata[`FSQ_STAT_BUSY] = s.seq != SEQ_IDLE;
        end
        default: n.rdata = 32'h00000000;
      endcase
    end
    if (req && AVS_WRITE) begin
      unique case (AVS_ADDRESS)
        `FSQ_OFS_CTRL: begin
          if (AVS_BYTEENABLE[0]) begin
            n.sel = AVS_WRITEDATA[`FSQ_CTRL_SEL +: 2];
            n.free = AVS_WRITEDATA[`FSQ_CTRL_FREE];
            // only firmware changes the gate
            n.write_enable_gate = AVS_WRITEDATA[`FSQ_CTRL_WRITE_ENABLE_GATE]; // R11
            if (!AVS_WRITEDATA[`FSQ_CTRL_ERR]) begin
              n.err = 1'b0;
            end
            // read start is refused in flash space
            n.rd = AVS_WRITEDATA[`FSQ_CTRL_RD] && s.sel != `FSQ_SEL_PFM; // R23
            // start bit counts only with the gate already set
            start_try = AVS_WRITEDATA[`FSQ_CTRL_WR] && s.write_enable_gate; // R8
            other_wr = !start_try;
          end
        end
        `FSQ_OFS_KEY: key_wr = AVS_BYTEENABLE[0];
        `FSQ_OFS_PTR: begin
          other_wr = 1'b1;
          wmerge = merge({10'h000, s.ptr}, AVS_WRITEDATA, AVS_BYTEENABLE);
          n.ptr = wmerge[21:0];
        end
        `FSQ_OFS_LATCH: begin
          other_wr = 1'b1;
          if (AVS_BYTEENABLE[0]) begin
            n.lat = AVS_WRITEDATA[7:0];
          end
        end
        `FSQ_OFS_OP: begin
          other_wr = 1'b1;
          if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[`FSQ_OP_TABLE_READ_OP]) begin
            n.lat = id_byte; // R15 R16
          end else if (AVS_BYTEENABLE[0] &&
                       AVS_WRITEDATA[`FSQ_OP_TABLE_WRITE_OP] &&
                       s.sel == `FSQ_SEL_PFM) begin
            // short write: only the holding register changes
            n.hold[s.ptr[`FSQ_HOLD_AW-1:0]] = s.lat;
          end
          if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[`FSQ_OP_INC] &&
              (AVS_WRITEDATA[`FSQ_OP_TABLE_READ_OP] ||
               AVS_WRITEDATA[`FSQ_OP_TABLE_WRITE_OP])) begin
            n.ptr = s.ptr + 22'h000001;
          end
        end
        `FSQ_OFS_STAT: begin
          other_wr = 1'b1;
          if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[`FSQ_STAT_DONE]) begin
            n.done = 1'b0;
          end
        end
        // any write between key and start breaks the unlock, except control or key writes with byte lane 0 disabled
        default: other_wr = 1'b1; // R9
      endcase
    end
    // a start without a fresh unlock is dropped silently
    if (start_try && armed) begin // R9
      n.wptr = s.ptr;
      if (s.sel == `FSQ_SEL_PFM) begin
        if (in_pfm && !PFM_WRITE_PROTECT) begin
          n.seq = SEQ_PFM;
          n.wr = 1'b1;
          n.stall = 1'b1; // R1
          tmr_start = 1'b1;
        end else begin
          n.err = 1'b1; // R24
        end
      end else if (s.sel[0] &&
                   (in_uid || (in_cfg && CONFIG_WRITE_PROTECT))) begin // R13
        n.seq = SEQ_CFG;
        n.wr = 1'b1;
        n.stall = 1'b1; // R20
        tmr_start = 1'b1;
        tmr_load = CFG_US;
      end else begin
        // config with CONFIG_WRITE_PROTECT low, device id range, undecoded address or select 00
        n.err = 1'b1; // R18 R26
      end
    end
    if (tmr_done && !cpu_reset) begin
      if (s.seq == SEQ_PFM) begin
        pfm_commit = 1'b1;
        // an erase keeps the holding registers
        if (!s.free) begin
          n.hold = {`FSQ_HOLD_BYTES{`FSQ_ERASED_BYTE}}; // R25
        end
      end else if (s.seq == SEQ_CFG) begin
        // whole byte replaced: erase and program in one step
        if (s.wptr >= `FSQ_CFG_BASE) begin
          n.cfg[s.wptr[3:0]] = s.lat; // R19 R21
        end else begin
          n.uid[s.wptr[3:0]] = s.lat; // R19
        end
      end
      n.seq = SEQ_IDLE;
      n.wr = 1'b0; // R20
      n.stall = 1'b0; // R21
      n.done = 1'b1; // R20 R25
    end
    if (cpu_reset) begin
      if (s.seq != SEQ_IDLE) begin
        n.err = 1'b1; // R7
      end
      n.seq = SEQ_IDLE;
      n.wr = 1'b0;
      n.stall = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.seq <= SEQ_IDLE;
      {s.sel, s.rd, s.wr, s.write_enable_gate, s.err, s.free} <= 7'(`FSQ_CTRL_RST);
      s.hold <= {`FSQ_HOLD_BYTES{`FSQ_ERASED_BYTE}};
      s.uid <= {`FSQ_UID_BYTES{`FSQ_ERASED_BYTE}};
      s.cfg <= {`FSQ_CFG_BYTES{`FSQ_ERASED_BYTE}};
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // flash array; programming only clears bits, ff leaves a byte alone
  always_ff @(posedge CLK_SYS) begin
    if (pfm_commit) begin
      for (int i = 0; i < `FSQ_HOLD_BYTES; i++) begin
        if (s.free) begin
          pfm[{s.wptr[PFM_AW-1:`FSQ_HOLD_AW], 6'(i)}] <= `FSQ_ERASED_BYTE;
        end else begin
          pfm[{s.wptr[PFM_AW-1:`FSQ_HOLD_AW], 6'(i)}] <=
            pfm[{s.wptr[PFM_AW-1:`FSQ_HOLD_AW], 6'(i)}] & s.hold[i];
        end
      end
    end
  end

  // ==========================================================
  // helpers
  fsq_timer #(
    .DIV(`FSQ_US_DIV)
  ) u_timer (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .start(tmr_start),
    .abort(tmr_abort),
    .load(tmr_load),
    .done(tmr_done),
    .busy()
  );

  fsq_unlock u_unlock (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .key_wr(key_wr),
    .key_data(AVS_WRITEDATA[7:0]),
    .other_wr(other_wr || cpu_reset),
    .start_try(start_try),
    .armed(armed)
  );

  assign AVS_READDATA = s.rdata;
  assign AVS_WAITREQUEST = s.waitreq;
  assign CPU_STALL = s.stall;
  assign MEMORY_DONE_FLAG = s.done;
  assign CONFIG_WORDS = s.cfg;

endmodule

`default_nettype wire

//--- testbench/fsq_cpu.sv
// cpu side of the register bus: one access at a time
// assumes calls come just after a rising edge of clk
`timescale 1ns/100ps
`default_nettype none
module fsq_cpu (
  input wire logic clk,
  input wire logic wait_req,
  input wire logic [31:0] rdata,
  output logic [4:0] addr,
  output logic rd,
  output logic wr,
  output logic [31:0] wdata
);
  // =====
  // bus cycle
  initial begin
    addr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
  end
  // held until waitrequest is seen low, so long writes stall us too
  task automatic xfer(input logic r, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
    rd <= r;
    wr <= !r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- testbench/fsq_chk.sv
// port assertions of the sequencer
// assumes binding into fsq_top with its timing parameters
`timescale 1ns/100ps
`default_nettype none
`include "fsq_params.svh"
module fsq_chk
  import fsq_pkg::*;
#(
  parameter logic [15:0] PROG_US = 16'h0003,
  parameter logic [15:0] CFG_US = 16'h0002
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic EXT_RESET_EVT,
  input wire logic WDT_RESET_EVT,
  input wire logic CPU_STALL,
  input wire logic MEMORY_DONE_FLAG,
  input wire logic [8*`FSQ_CFG_BYTES-1:0] CONFIG_WORDS
);
  // =====
  // helpers
  logic [31:0] run;
  logic go;
  logic ev;
  assign go = AVS_WRITE && AVS_ADDRESS == 5'h00 && AVS_WRITEDATA[1];
  assign ev = EXT_RESET_EVT || WDT_RESET_EVT;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || !CPU_STALL)
      run <= 32'h0;
    else
      run <= run + 32'h1;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // =====
  // assertions
  a_stall_cause: assert property ($rose(CPU_STALL) |->
    $past(go) || $past(go, 2)) else $error("stall without start");
  a_stall_min: assert property ($fell(CPU_STALL) && !$past(ev)
    && !$past(ev, 2) |-> $past(run) + 32'd2 >= 32'(CFG_US) * 32'd20)
    else $error("write ended early");
  a_stall_max: assert property (CPU_STALL |->
    run <= 32'(PROG_US) * 32'd20 + 32'd8) else $error("write too long");
  // the start write itself is answered in the cycle the stall begins
  a_bus_frozen: assert property (CPU_STALL && $past(CPU_STALL) |->
    AVS_WAITREQUEST) else $error("bus answered in stall");
  a_wait_pulse: assert property (!AVS_WAITREQUEST |=>
    AVS_WAITREQUEST) else $error("waitrequest low too long");
  a_event_abort: assert property (ev |-> ##[1:2] !CPU_STALL)
    else $error("reset event did not abort");
  a_done_end: assert property ($rose(MEMORY_DONE_FLAG) |->
    $past(CPU_STALL) || $past(CPU_STALL, 2)) else $error("stray done");
  a_done_hold: assert property ($fell(MEMORY_DONE_FLAG) |->
    $past(AVS_WRITE && AVS_ADDRESS == 5'h14 && AVS_WRITEDATA[0]))
    else $error("done lost");
  a_cfg_moves: assert property ($changed(CONFIG_WORDS) |->
    $past(CPU_STALL) ##[0:2] !CPU_STALL) else $error("config moved");
  c_end: cover property ($fell(CPU_STALL));
  c_done: cover property ($rose(MEMORY_DONE_FLAG));
  c_abort: cover property (ev && CPU_STALL);
endmodule
bind fsq_top fsq_chk #(.PROG_US(PROG_US), .CFG_US(CFG_US)) i_chk (.*);
`default_nettype wire

//--- testbench/fsq_top_tb.sv
// self-checking bench of the flash sequencer
// assumes fsq_cpu drives the bus and fsq_chk is bound in
`timescale 1ns/100ps
`default_nettype none
`include "fsq_params.svh"
module fsq_top_tb
  import fsq_pkg::*;
;
  localparam logic [15:0] DID = 16'h1234;
  localparam logic [15:0] RID = 16'h0001;
  localparam logic [4:0] CT = `FSQ_OFS_CTRL, KY = `FSQ_OFS_KEY;
  localparam logic [4:0] PT = `FSQ_OFS_PTR, LT = `FSQ_OFS_LATCH;
  localparam logic [4:0] OP = `FSQ_OFS_OP, ST = `FSQ_OFS_STAT;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ext = 1'b0;
  logic wdt = 1'b0;
  logic cprot = 1'b0;
  logic pprot = 1'b0;
  logic wreq, rd, wr, stall, done;
  logic [4:0] addr;
  logic [31:0] wdat, rdat, q;
  logic [95:0] cfg;
  int bad_count = 0;
  int compares = 0;
  // pointer, latch expected
  logic [29:0] rrow [10] = '{{22'h200000, 8'hff}, {22'h20000f, 8'hff},
    {22'h200010, 8'h00}, {22'h300000, 8'hff}, {22'h30000b, 8'hff},
    {22'h30000c, 8'h00}, {22'h3ffffb, 8'h00}, {22'h3ffffc, RID[7:0]},
    {22'h3ffffd, RID[15:8]}, {22'h3fffff, DID[15:8]}};
  // pointer, config protect, error expected, read back
  logic [31:0] wrow [5] = '{{22'h300001, 2'b10, 8'h5a},
    {22'h200003, 2'b00, 8'h5a}, {22'h300002, 2'b01, 8'hff},
    {22'h3ffffe, 2'b11, DID[7:0]}, {22'h300010, 2'b11, 8'h00}};
  fsq_top #(.PROG_US(16'h0003), .CFG_US(16'h0002), .DEV_ID(DID),
    .REV_ID(RID)) i_dut (.CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .EXT_RESET_EVT(ext), .WDT_RESET_EVT(wdt),
    .CONFIG_WRITE_PROTECT(cprot), .PFM_WRITE_PROTECT(pprot),
    .CPU_STALL(stall), .MEMORY_DONE_FLAG(done), .CONFIG_WORDS(cfg));
  fsq_cpu i_cpu (.clk(clk), .wait_req(wreq), .rdata(rdat), .addr(addr),
    .rd(rd), .wr(wr), .wdata(wdat));
  always #25 clk = ~clk;
  // =====
  // tasks
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bw(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_cpu.xfer(1'b0, a, d, x);
  endtask
  task automatic br(input logic [4:0] a);
    i_cpu.xfer(1'b1, a, 32'h0, q);
  endtask
  task automatic key();
    bw(KY, 32'(`FSQ_KEY_FIRST));
    bw(KY, 32'(`FSQ_KEY_SECOND));
  endtask
  // gate set by its own write before the keys
  task automatic launch(input logic [31:0] c);
    bw(CT, c);
    key();
    bw(CT, c | 32'h2);
  endtask
  task automatic rdn(input logic [31:0] o, input logic [7:0] e);
    bw(OP, o);
    br(LT);
    chk(q, e);
  endtask
  task automatic tread(input logic [21:0] p, input logic [7:0] e);
    bw(PT, 32'(p));
    rdn(32'h1, e);
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // =====
  // sequence
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(cfg, '1);
    chk({stall, done, wreq}, 3'b001);
    br(CT);
    chk(q, 32'h0);
    bw(CT, 32'h44);
    foreach (rrow[i]) tread(rrow[i][29:8], rrow[i][7:0]);
    bw(CT, 32'h46);
    key();
    bw(PT, 32'h0);
    bw(CT, 32'h46);
    bw(CT, 32'h40);
    key();
    bw(CT, 32'h42);
    br(CT);
    chk({stall, done, q}, {2'b00, 32'h40});
    foreach (wrow[i]) begin
      cprot <= wrow[i][9];
      bw(PT, 32'(wrow[i][31:10]));
      bw(LT, 32'h5a);
      launch(i[0] ? 32'hc4 : 32'h44);
      br(CT);
      chk(q[3:1], {wrow[i][8], 2'b10});
      chk(done, !wrow[i][8]);
      bw(ST, 32'h1);
      tread(wrow[i][31:10], wrow[i][7:0]);
    end
    chk(cfg[23:0], 24'hff5aff);
    bw(PT, 32'h0);
    launch(32'h94);
    bw(ST, 32'h1);
    bw(LT, 32'h0f);
    bw(OP, 32'h6);
    bw(LT, 32'ha5);
    bw(OP, 32'h6);
    bw(PT, 32'h0);
    launch(32'h84);
    br(CT);
    chk({done, q}, {1'b1, 32'h84});
    rdn(32'h5, 8'h0f);
    rdn(32'h5, 8'ha5);
    rdn(32'h1, 8'hff);
    pprot <= 1'b1;
    launch(32'h84);
    br(CT);
    chk({stall, q}, {1'b0, 32'h8c});
    pprot <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      launch(32'h94);
      ext <= (k == 0);
      wdt <= (k == 1);
      @(posedge clk);
      ext <= 1'b0;
      wdt <= 1'b0;
      br(CT);
      chk(q, 32'h9c);
    end
    report_and_stop();
  end
  initial begin
    #1000000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
